// ===== design/sbprm_pkg.sv
// Constants, field layout and carrier types of the serial bus PHY register map.
package sbprm_pkg;

  // Clock and bus reset timing.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned BUS_RESET_TIME_US = 166;
  localparam int unsigned BUS_RESET_CYCLES = (BUS_RESET_TIME_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int BUS_RESET_CNT_W = 16;

  // AXI4-Lite geometry and responses.
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 5;
  localparam int ADDR_TOP_LSB = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; the byte address is four times the index.
  localparam int REG_IDX_W = 4;
  localparam int REG_W = 8;
  localparam logic [REG_IDX_W-1:0] IDX_NODE_IDENTITY = 4'h0;
  localparam logic [REG_IDX_W-1:0] IDX_RESET_GAP = 4'h1;
  localparam logic [REG_IDX_W-1:0] IDX_MAP_PORTS = 4'h2;
  localparam logic [REG_IDX_W-1:0] IDX_SPEED_DELAY = 4'h3;
  localparam logic [REG_IDX_W-1:0] IDX_SELF_ID_CONTENT = 4'h4;
  localparam logic [REG_IDX_W-1:0] IDX_EVENT_ARB = 4'h5;
  localparam logic [REG_IDX_W-1:0] IDX_RESERVED = 4'h6;
  localparam logic [REG_IDX_W-1:0] IDX_PAGE_PORT = 4'h7;
  localparam logic [REG_IDX_W-1:0] IDX_WINDOW_FIRST = 4'h8;
  localparam logic [REG_IDX_W-1:0] IDX_WINDOW_LAST = 4'hF;
  localparam int WINDOW_IDX_W = 3;
  localparam int WINDOW_BYTES = 8;

  // Field positions inside the byte-wide registers.
  localparam int NODE_NUM_LSB = 2;
  localparam int NODE_NUM_W = 6;
  localparam int ROOT_BIT = 1;
  localparam int CABLE_POWER_BIT = 0;
  localparam int ROOT_HOLDOFF_BIT = 7;
  localparam int IMM_RESET_BIT = 6;
  localparam int GAP_LSB = 0;
  localparam int GAP_W = 6;
  localparam int EXT_LSB = 5;
  localparam int EXT_W = 3;
  localparam int PORTS_LSB = 0;
  localparam int PORTS_W = 5;
  localparam int SPEED_LSB = 5;
  localparam int SPEED_W = 3;
  localparam int DELAY_LSB = 0;
  localparam int DELAY_W = 4;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_W = 3;
  localparam int PORT_SEL_LSB = 0;
  localparam int PORT_SEL_W = 4;

  // Reset and fixed values.
  localparam logic [NODE_NUM_W-1:0] NODE_UNCONFIGURED = 6'h3F;
  localparam logic [GAP_W-1:0] GAP_RESET = 6'h3F;
  localparam logic [EXT_W-1:0] EXT_MAP_CODE = 3'h7;
  localparam logic [PORTS_W-1:0] PORT_COUNT = 5'h03;
  localparam logic [SPEED_W-1:0] SPEED_S100 = 3'h0;
  localparam logic [SPEED_W-1:0] SPEED_S200 = 3'h1;
  localparam logic [SPEED_W-1:0] SPEED_S400 = 3'h2;
  localparam logic [SPEED_W-1:0] TOP_SPEED = SPEED_S400;
  localparam logic [DELAY_W-1:0] REPEAT_DELAY = 4'h0;
  localparam int unsigned DELAY_BASE_NS = 144;
  localparam int unsigned DELAY_STEP_NS = 20;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [PORT_SEL_W-1:0] port;
  } sbprm_page_s;

  typedef struct packed {
    logic wr;
    logic [WINDOW_IDX_W-1:0] index;
    logic [REG_W-1:0] data;
  } sbprm_pwrite_s;

endpackage

// ===== design/sbprm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module sbprm_pin_sync
  import sbprm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // The output moves only once the second and third stages agree.
  always_comb begin
    next_level = level_o;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_sync_agree;
    $changed(level_o) |-> ($past(s2) == $past(s3)) && (level_o == $past(s3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("Cable power changed without stage agreement.");

endmodule

// ===== design/sbprm_reset_timer.sv
// Timer that holds the immediate bus reset state for a fixed number of cycles.
`timescale 1ns/1ps
module sbprm_reset_timer
  import sbprm_pkg::*;
#(
  parameter int unsigned CYCLES = BUS_RESET_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic active_o
);

  typedef enum logic {TMR_IDLE, TMR_RUN} sbprm_tmr_e;

  localparam logic [BUS_RESET_CNT_W-1:0] LAST = BUS_RESET_CNT_W'(CYCLES - 1);

  sbprm_tmr_e state;
  sbprm_tmr_e next_state;
  logic [BUS_RESET_CNT_W-1:0] count;
  logic [BUS_RESET_CNT_W-1:0] next_count;

  // A new start restarts the hold, so a request is never lost to the end of a previous one.
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      TMR_IDLE: begin
        next_count = '0;
      end
      TMR_RUN: begin
        if (count == LAST) begin
          next_state = TMR_IDLE;
        end else begin
          next_count = count + 1'b1;
        end
      end
    endcase
    if (start_i) begin
      next_state = TMR_RUN;
      next_count = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= TMR_IDLE;
      count <= '0;
      active_o <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      active_o <= (next_state == TMR_RUN);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_hold_length;
    $fell(active_o) |-> ($past(count) == LAST) && !$past(start_i);
  endproperty
  a_hold_length: assert property (p_hold_length) else $error("Bus reset hold ended early or late.");

endmodule

// ===== design/sbprm_top.sv
// AXI4-Lite register map of a three-port serial bus cable PHY.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module sbprm_top
  import sbprm_pkg::*;
#(
  parameter int unsigned BUS_RESET_CYCLES_P = BUS_RESET_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [AXI_ADDR_W-1:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [AXI_DATA_W-1:0] AXI_WDATA_I,
  input wire logic [AXI_STRB_W-1:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [AXI_ADDR_W-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [AXI_DATA_W-1:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic [NODE_NUM_W-1:0] NODE_NUMBER_I,
  input wire logic NODE_NUMBER_VALID_I,
  input wire logic ROOT_I,
  input wire logic CABLE_POWER_I,
  input wire logic [WINDOW_BYTES*REG_W-1:0] PAGED_RDATA_I,
  output logic ROOT_HOLDOFF_O,
  output logic BUS_RESET_O,
  output logic [GAP_W-1:0] GAP_COUNT_O,
  output logic LINK_TX_INHIBIT_O,
  output sbprm_page_s PAGE_CHOICE_O,
  output sbprm_pwrite_s PAGED_WRITE_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and helpers.

  logic aw_held;
  logic next_aw_held;
  logic [REG_IDX_W-1:0] aw_idx;
  logic [REG_IDX_W-1:0] next_aw_idx;
  logic aw_bad;
  logic next_aw_bad;
  logic w_held;
  logic next_w_held;
  logic [REG_W-1:0] w_byte;
  logic [REG_W-1:0] next_w_byte;
  logic w_lane0;
  logic next_w_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [AXI_DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic [NODE_NUM_W-1:0] node_number;
  logic [NODE_NUM_W-1:0] next_node_number;
  logic root_flag;
  logic next_root_flag;
  logic next_root_holdoff;
  logic [GAP_W-1:0] next_gap_count;
  sbprm_page_s next_page_choice;
  sbprm_pwrite_s next_paged_write;
  logic cable_power;
  logic wr_fire;
  logic reg_write;
  logic ibr_start;
  logic [REG_IDX_W-1:0] ar_idx;
  logic ar_bad;
  logic [REG_W-1:0] window_byte;

  assign wr_fire = aw_held && w_held && !AXI_BVALID_O;
  assign reg_write = wr_fire && !aw_bad && w_lane0;
  assign ibr_start = reg_write && (aw_idx == IDX_RESET_GAP) && w_byte[IMM_RESET_BIT];
  assign ar_idx = AXI_ARADDR_I[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign ar_bad = |AXI_ARADDR_I[AXI_ADDR_W-1:ADDR_TOP_LSB];
  assign window_byte = PAGED_RDATA_I[{ar_idx[WINDOW_IDX_W-1:0], 3'h0} +: REG_W];

  // A channel is refused only while its item is held or a response is pending.
  assign AXI_AWREADY_O = !aw_held && !AXI_BVALID_O;
  assign AXI_WREADY_O = !w_held && !AXI_BVALID_O;
  assign AXI_ARREADY_O = !AXI_RVALID_O;

  // Misconfigured bus: the link must not transmit.
  assign LINK_TX_INHIBIT_O = (node_number == NODE_UNCONFIGURED);

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules.

  sbprm_pin_sync u_power_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .pin_i(CABLE_POWER_I),
    .level_o(cable_power)
  );

  // The timer's active flag doubles as the self-clearing request bit; writing 0 cannot abort it.
  sbprm_reset_timer #(
    .CYCLES(BUS_RESET_CYCLES_P)
  ) u_reset_timer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .start_i(ibr_start),
    .active_o(BUS_RESET_O)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux.

  function automatic logic [REG_W-1:0] read_byte(input logic [REG_IDX_W-1:0] idx, input logic [REG_W-1:0] win);
    logic [REG_W-1:0] b;
    b = '0;
    unique case (idx)
      IDX_NODE_IDENTITY: begin
        b[NODE_NUM_LSB +: NODE_NUM_W] = node_number;
        b[ROOT_BIT] = root_flag;
        b[CABLE_POWER_BIT] = cable_power;
      end
      IDX_RESET_GAP: begin
        b[ROOT_HOLDOFF_BIT] = ROOT_HOLDOFF_O;
        b[IMM_RESET_BIT] = BUS_RESET_O;
        b[GAP_LSB +: GAP_W] = GAP_COUNT_O;
      end
      IDX_MAP_PORTS: begin
        b[EXT_LSB +: EXT_W] = EXT_MAP_CODE;
        b[PORTS_LSB +: PORTS_W] = PORT_COUNT;
      end
      IDX_SPEED_DELAY: begin
        b[SPEED_LSB +: SPEED_W] = TOP_SPEED;
        b[DELAY_LSB +: DELAY_W] = REPEAT_DELAY;
      end
      IDX_SELF_ID_CONTENT, IDX_EVENT_ARB, IDX_RESERVED: begin
        b = '0;
      end
      IDX_PAGE_PORT: begin
        b[PAGE_LSB +: PAGE_W] = PAGE_CHOICE_O.page;
        b[PORT_SEL_LSB +: PORT_SEL_W] = PAGE_CHOICE_O.port;
      end
      default: begin
        b = win;
      end
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next values.

  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_aw_bad = aw_bad;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = AXI_BVALID_O;
    next_bresp = AXI_BRESP_O;
    next_rvalid = AXI_RVALID_O;
    next_rdata = AXI_RDATA_O;
    next_rresp = AXI_RRESP_O;
    next_node_number = node_number;
    next_root_flag = ROOT_I;
    next_root_holdoff = ROOT_HOLDOFF_O;
    next_gap_count = GAP_COUNT_O;
    next_page_choice = PAGE_CHOICE_O;
    next_paged_write = PAGED_WRITE_O;
    next_paged_write.wr = 1'b0;
    if (NODE_NUMBER_VALID_I) begin
      next_node_number = NODE_NUMBER_I;
    end
    if (AXI_AWVALID_I && AXI_AWREADY_O) begin
      next_aw_held = 1'b1;
      next_aw_idx = AXI_AWADDR_I[ADDR_IDX_MSB:ADDR_IDX_LSB];
      next_aw_bad = |AXI_AWADDR_I[AXI_ADDR_W-1:ADDR_TOP_LSB];
    end
    if (AXI_WVALID_I && AXI_WREADY_O) begin
      next_w_held = 1'b1;
      next_w_byte = AXI_WDATA_I[REG_W-1:0];
      next_w_lane0 = AXI_WSTRB_I[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = aw_bad ? RESP_SLVERR : RESP_OKAY;
    end
    if (AXI_BVALID_O && AXI_BREADY_I) begin
      next_bvalid = 1'b0;
    end
    if (reg_write) begin
      if (aw_idx == IDX_RESET_GAP) begin
        next_root_holdoff = w_byte[ROOT_HOLDOFF_BIT];
        next_gap_count = w_byte[GAP_LSB +: GAP_W];
      end else if (aw_idx == IDX_PAGE_PORT) begin
        next_page_choice.page = w_byte[PAGE_LSB +: PAGE_W];
        next_page_choice.port = w_byte[PORT_SEL_LSB +: PORT_SEL_W];
      end else if (aw_idx >= IDX_WINDOW_FIRST) begin
        next_paged_write.wr = 1'b1;
        next_paged_write.index = aw_idx[WINDOW_IDX_W-1:0];
        next_paged_write.data = w_byte;
      end
    end
    if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_SLVERR;
      if (!ar_bad) begin
        next_rdata[REG_W-1:0] = read_byte(ar_idx, window_byte);
        next_rresp = RESP_OKAY;
      end
    end
    if (AXI_RVALID_O && AXI_RREADY_I) begin
      next_rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
      aw_bad <= 1'b0;
      w_held <= 1'b0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= '0;
      AXI_RRESP_O <= RESP_OKAY;
      node_number <= NODE_UNCONFIGURED;
      root_flag <= 1'b0;
      ROOT_HOLDOFF_O <= 1'b0;
      GAP_COUNT_O <= GAP_RESET;
      PAGE_CHOICE_O <= '0;
      PAGED_WRITE_O <= '0;
    end else begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      aw_bad <= next_aw_bad;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      AXI_BVALID_O <= next_bvalid;
      AXI_BRESP_O <= next_bresp;
      AXI_RVALID_O <= next_rvalid;
      AXI_RDATA_O <= next_rdata;
      AXI_RRESP_O <= next_rresp;
      node_number <= next_node_number;
      root_flag <= next_root_flag;
      ROOT_HOLDOFF_O <= next_root_holdoff;
      GAP_COUNT_O <= next_gap_count;
      PAGE_CHOICE_O <= next_page_choice;
      PAGED_WRITE_O <= next_paged_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_reg_write(logic [REG_IDX_W-1:0] idx);
    wr_fire && !aw_bad && w_lane0 && (aw_idx == idx);
  endsequence

  sequence s_read_taken(logic [REG_IDX_W-1:0] idx);
    AXI_ARVALID_I && AXI_ARREADY_O && !ar_bad && (ar_idx == idx);
  endsequence

  property p_node_ro;
    !$past(NODE_NUMBER_VALID_I) |-> $stable(node_number);
  endproperty
  a_node_ro: assert property (p_node_ro) else $error("Node number changed without self-id update.");

  property p_inhibit;
    NODE_NUMBER_VALID_I && (NODE_NUMBER_I == NODE_UNCONFIGURED) |=> LINK_TX_INHIBIT_O;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Link not inhibited for node number 63.");

  property p_root_read;
    s_read_taken(IDX_NODE_IDENTITY) |=> AXI_RDATA_O[ROOT_BIT] == $past(root_flag) && root_flag == $past(ROOT_I);
  endproperty
  a_root_read: assert property (p_root_read) else $error("Root flag read back wrong.");

  property p_holdoff;
    s_reg_write(IDX_RESET_GAP) |=> ROOT_HOLDOFF_O == $past(w_byte[ROOT_HOLDOFF_BIT]);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("Root hold-off did not follow write.");

  property p_ibr_start;
    s_reg_write(IDX_RESET_GAP) ##0 w_byte[IMM_RESET_BIT] |=> BUS_RESET_O [*2];
  endproperty
  a_ibr_start: assert property (p_ibr_start) else $error("Immediate bus reset did not start.");

  property p_ibr_clear;
    s_read_taken(IDX_RESET_GAP) |=> AXI_RDATA_O[IMM_RESET_BIT] == $past(BUS_RESET_O);
  endproperty
  a_ibr_clear: assert property (p_ibr_clear) else $error("Bus reset bit read back wrong.");

  property p_gap;
    s_reg_write(IDX_RESET_GAP) |=> GAP_COUNT_O == $past(w_byte[GAP_LSB +: GAP_W]) ##1 $stable(GAP_COUNT_O);
  endproperty
  a_gap: assert property (p_gap) else $error("Gap count did not follow write.");

  property p_map_ports;
    s_read_taken(IDX_MAP_PORTS) |=> AXI_RDATA_O == {24'h000000, EXT_MAP_CODE, PORT_COUNT};
  endproperty
  a_map_ports: assert property (p_map_ports) else $error("Map code or port count wrong.");

  property p_speed_delay;
    s_read_taken(IDX_SPEED_DELAY) |=> AXI_RDATA_O == {24'h000000, TOP_SPEED, 1'b0, REPEAT_DELAY};
  endproperty
  a_speed_delay: assert property (p_speed_delay) else $error("Speed or delay field wrong.");

  property p_window;
    AXI_ARVALID_I && AXI_ARREADY_O && !ar_bad && ar_idx[REG_IDX_W-1] |=> AXI_RDATA_O[REG_W-1:0] == $past(window_byte);
  endproperty
  a_window: assert property (p_window) else $error("Paged window read wrong.");

endmodule

// ===== test/sbprm_core_model.sv
// Behavioural model of the paged register store that sits behind the register window.
`timescale 1ns/1ps
module sbprm_core_model
  import sbprm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sbprm_page_s page_i,
  input wire sbprm_pwrite_s pwrite_i,
  output logic [WINDOW_BYTES*REG_W-1:0] rdata_o
);
  logic [REG_W-1:0] mem [WINDOW_BYTES*WINDOW_BYTES];
  ////////////////////////////////////////////////////////////////////////////////
  // Each byte starts as page number and byte number, so a wrong page choice reads back a wrong value.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < WINDOW_BYTES*WINDOW_BYTES; i++) begin
        mem[i] <= REG_W'(((i / WINDOW_BYTES) << 4) | (i % WINDOW_BYTES));
      end
    end else if (pwrite_i.wr) begin
      mem[{page_i.page, pwrite_i.index}] <= pwrite_i.data;
    end
  end
  always_comb begin
    for (int k = 0; k < WINDOW_BYTES; k++) begin
      rdata_o[k*REG_W +: REG_W] = mem[{page_i.page, 3'(k)}];
    end
  end
endmodule

// ===== test/tb_serial_bus_phy_register_map.sv
// Self-checking testbench of the register map over AXI4-Lite.
`timescale 1ns/1ps
module tb_serial_bus_phy_register_map
  import sbprm_pkg::*;
;
  // A short hold keeps the run brief; every expectation uses this value.
  localparam int unsigned RST_CYC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [5:0] node = 6'h00;
  logic node_vld = 1'b0, root = 1'b0, cpwr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, holdoff, bus_rst, inhibit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] gap;
  logic [63:0] paged;
  sbprm_page_s page_c;
  sbprm_pwrite_s pwr, last_pw;
  int errors = 0, cmp_count = 0, run_len = 0, last_run = 0;

  always #4 clk = ~clk;

  sbprm_top #(.BUS_RESET_CYCLES_P(RST_CYC)) DUT (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
    .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
    .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready), .NODE_NUMBER_I(node), .NODE_NUMBER_VALID_I(node_vld), .ROOT_I(root),
    .CABLE_POWER_I(cpwr), .PAGED_RDATA_I(paged), .ROOT_HOLDOFF_O(holdoff), .BUS_RESET_O(bus_rst),
    .GAP_COUNT_O(gap), .LINK_TX_INHIBIT_O(inhibit), .PAGE_CHOICE_O(page_c), .PAGED_WRITE_O(pwr));

  sbprm_core_model core (.clk_i(clk), .rst_n_i(rst_n), .page_i(page_c), .pwrite_i(pwr), .rdata_o(paged));

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the last bus reset pulse, counted in clock edges at which it was high.
  always @(posedge clk) begin
    if (bus_rst === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_run <= run_len;
      run_len <= 0;
    end
    if (pwr.wr === 1'b1) begin
      last_pw <= pwr;
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk(32'(got), 32'(exp), "response");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks start just after an edge and end one idle edge later, so no signal is assigned twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk_resp(bresp, er);
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      errors++;
      test_done();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk(rdata, {24'h0, ed}, "read data");
        chk_resp(rresp, er);
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      errors++;
      test_done();
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rd(8'h00, {NODE_UNCONFIGURED, 2'b00}, RESP_OKAY);
    chk(32'(inhibit), 32'h1, "tx inhibit");
    rd(8'h04, {2'b00, GAP_RESET}, RESP_OKAY);
    chk(32'({holdoff, bus_rst, gap}), 32'h3F, "control outputs");
    rd(8'h08, 8'hE3, RESP_OKAY);
    rd(8'h0C, 8'h40, RESP_OKAY);
    wr(8'h08, 8'h00, RESP_OKAY);
    rd(8'h08, 8'hE3, RESP_OKAY);
    wr(8'h18, 8'hFF, RESP_OKAY);
    rd(8'h18, 8'h00, RESP_OKAY);
    $display("reset values test done");
  endtask

  task automatic t_node_status;
    node <= 6'h05;
    node_vld <= 1'b1;
    root <= 1'b1;
    cpwr <= 1'b1;
    @(posedge clk);
    node_vld <= 1'b0;
    // The cable power pin crosses a synchroniser, so allow it a few cycles to appear.
    repeat (8) @(posedge clk);
    rd(8'h00, 8'h17, RESP_OKAY);
    chk(32'(inhibit), 32'h0, "tx inhibit");
    wr(8'h00, 8'h00, RESP_OKAY);
    rd(8'h00, 8'h17, RESP_OKAY);
    node <= 6'h3F;
    node_vld <= 1'b1;
    root <= 1'b0;
    @(posedge clk);
    node_vld <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(inhibit), 32'h1, "tx inhibit");
    rd(8'h00, 8'hFD, RESP_OKAY);
    $display("node status test done");
  endtask

  task automatic t_gap_holdoff;
    wr(8'h04, 8'h85, RESP_OKAY);
    rd(8'h04, 8'h85, RESP_OKAY);
    chk(32'({holdoff, gap}), 32'h45, "holdoff and gap");
    // A write whose lowest byte lane is off must leave the control byte untouched.
    wstrb <= 4'hE;
    wr(8'h04, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h04, 8'h85, RESP_OKAY);
    $display("gap and holdoff test done");
  endtask

  task automatic t_bus_reset;
    int n;
    wr(8'h04, 8'h45, RESP_OKAY);
    chk(32'(bus_rst), 32'h1, "bus reset active");
    rd(8'h04, 8'h45, RESP_OKAY);
    for (n = 0; n < 100 && bus_rst !== 1'b0; n++) begin
      @(posedge clk);
    end
    chk(32'(n < 100), 32'h1, "bus reset ends");
    if (n == 100) begin
      test_done();
    end
    repeat (2) @(posedge clk);
    chk(32'(last_run), 32'(RST_CYC), "bus reset length");
    rd(8'h04, 8'h05, RESP_OKAY);
    $display("bus reset test done");
  endtask

  task automatic t_window;
    wr(8'h1C, 8'hA3, RESP_OKAY);
    chk(32'(page_c), 32'({3'h5, 4'h3}), "page choice");
    rd(8'h1C, 8'hA3, RESP_OKAY);
    wr(8'h28, 8'h5C, RESP_OKAY);
    chk(32'(last_pw), 32'({1'b1, 3'h2, 8'h5C}), "paged write");
    rd(8'h28, 8'h5C, RESP_OKAY);
    rd(8'h3C, 8'h57, RESP_OKAY);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(8'hC0, 8'h12, RESP_SLVERR);
    $display("window test done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_node_status();
    t_gap_holdoff();
    t_bus_reset();
    t_window();
    test_done();
  end
endmodule
